// ---- include/i2cms_params.svh ----
`ifndef I2CMS_PARAMS_SVH
`define I2CMS_PARAMS_SVH
// Function
// R1: No rate divider counting while asleep
// R2: SCL period equals two divider countdowns
// R3: Released SCL waits sampled high, then reload
// R4: Start: both high, count, drive SDA low
// R5: Start: one more period, clear enable, hold
// R6: Lines low or early SCL low: collision
// R7: Buffer write during start: write collision
// R8: Low control bits locked until start completes
// R9: Restart: SCL low, release SDA, release SCL
// R10: Restart: high period, SDA low period, finish
// R11: Begin flag early, irq flag after timeout
// R12: Restart ignored while another event runs
// R13: Restart collision on SDA low or SCL
// R14: Restart locks buffer and low control bits
// R15: Buffer write sets full, starts divider
// R16: SDA changes after fall, low/high one period
// R17: Seven address bits then direction, MSB first
// R18: Eighth fall clears full, releases SDA
// R19: Ninth fall samples acknowledge into status
// R20: After ninth clock irq flag, divider halts
// R21: Write while shifting: collision, short window
// R22: Software clears the write collision flag
// R23: Divider decrements twice per instruction cycle
// R24: Software never programs a zero reload
// R25: Reset or disable returns to idle

// ----
// Register byte addresses
// ----
`define I2CMS_OFS_CTRL2 8'h00
`define I2CMS_OFS_STATUS 8'h04
`define I2CMS_OFS_RELOAD 8'h08
`define I2CMS_OFS_SBUF 8'h0C
`define I2CMS_OFS_FLAGS 8'h10
`define I2CMS_OFS_CONFIG 8'h14

// ----
// Field positions
// ----
`define I2CMS_CTRL2_SEN 0
`define I2CMS_CTRL2_RESTART_ENABLE_BIT 1
`define I2CMS_CTRL2_ACK_DATA_BIT 5
`define I2CMS_CTRL2_ACK_STATUS_FLAG 6
`define I2CMS_STATUS_BF 0
`define I2CMS_STATUS_BEGIN 3
`define I2CMS_FLAGS_IRQ 0
`define I2CMS_FLAGS_BCL 1
`define I2CMS_FLAGS_WRITE_COLLISION_FLAG 2
`define I2CMS_CONFIG_EN 0

// ----
// Reset values
// ----
`define I2CMS_RELOAD_RST 7'h63
`define I2CMS_BYTE_RST 8'h00

// ----
// Timing
// ----
`define I2CMS_CLK_NS 50
`define I2CMS_TCY_NS 100
`define I2CMS_DEC_PER_TCY 2
`define I2CMS_WRITE_COLLISION_FLAG_WIN_TCY 2
`define I2CMS_DEC_CYC (`I2CMS_TCY_NS / (`I2CMS_DEC_PER_TCY * `I2CMS_CLK_NS))
`define I2CMS_WRITE_COLLISION_FLAG_WIN_CYC ((`I2CMS_WRITE_COLLISION_FLAG_WIN_TCY * `I2CMS_TCY_NS + `I2CMS_CLK_NS - 1) / `I2CMS_CLK_NS)
`endif

// ---- include/i2cms_pkg.sv ----
package i2cms_pkg;
   // Sequencer phases
   typedef enum logic [3:0] {
      PH_IDLE,
      PH_ST_ARM,
      PH_ST_WAIT,
      PH_ST_HOLD,
      PH_RS_LOW,
      PH_RS_SDA,
      PH_RS_RISE,
      PH_RS_HIGH,
      PH_RS_SDALO,
      PH_TX_FALL,
      PH_TX_LOW,
      PH_TX_WAIT,
      PH_TX_HIGH
   } i2cms_phase_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } i2cms_bus_req_t;

   // Bus line levels
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cms_line_t;

   // Whole state of the sequencer
   typedef struct packed {
      i2cms_phase_t phase;
      logic [6:0] brg_cnt;
      logic brg_run;
      logic [3:0] dec_div;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] sbuf;
      logic [6:0] reload;
      logic start_enable_bit;
      logic restart_enable_bit;
      logic ack_dt;
      logic ack_stat;
      logic bf;
      logic bdet;
      logic irqf;
      logic bclf;
      logic write_collision_flag;
      logic [2:0] wwin;
      logic en;
      logic scl_oe_n;
      logic sda_oe_n;
      logic [7:0] rdata;
   } i2cms_state_t;
endpackage

// ---- rtl/i2cms_seq.sv ----
`timescale 1ns/1ps
`include "i2cms_params.svh"
// Master-side bus sequencer: start, repeated start and byte transmit.
module i2cms_seq #(
   parameter int RELOAD_W = 7
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire i2cms_pkg::i2cms_bus_req_t i_bus,
   output logic [7:0] o_rdata,
   input wire logic i_sleep,
   input wire i2cms_pkg::i2cms_line_t i_line,
   output i2cms_pkg::i2cms_line_t o_line,
   output i2cms_pkg::i2cms_line_t o_line_oe_n
);
   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (RELOAD_W != 7) begin : g_chk
      $error("i2cms_seq supports only a seven bit reload field");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [3:0] DEC_CYC = 4'(`I2CMS_DEC_CYC); // Clocks per decrement
   localparam logic [2:0] WIN_CYC = 3'(`I2CMS_WRITE_COLLISION_FLAG_WIN_CYC); // Rewrite window
   i2cms_pkg::i2cms_state_t st_q; // Registered state
   i2cms_pkg::i2cms_state_t st_d; // Next state
   i2cms_pkg::i2cms_line_t lvl; // Synchronised line levels
   logic dec_en; // Decrement enable pulse
   logic tmo; // Divider timed out this cycle

   // ----------------------------------------------------------------
   // Line synchroniser
   // ----------------------------------------------------------------
   i2cms_sync #(
      .W(2)
   ) u_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_pin({i_line.scl, i_line.sda}),
      .o_lvl({lvl.scl, lvl.sda})
   );

   // ----------------------------------------------------------------
   // Divider strobes
   // ----------------------------------------------------------------
   // Decrement pulse stops in sleep so no SCL timing advances there
   assign dec_en = (st_q.dec_div == 4'h0) && !i_sleep; // R1 R23
   assign tmo = dec_en && st_q.brg_run && (st_q.brg_cnt == 7'h00);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic bcl; // Collision seen this cycle
      logic load; // Reload the divider this cycle
      logic sw_w; // Software write to shift buffer
      bcl = 1'b0;
      load = 1'b0;
      sw_w = 1'b0;
      st_d = st_q;
      st_d.rdata = `I2CMS_BYTE_RST;

      // Instruction-rate divider, free running outside sleep
      if (i_sleep) begin
         st_d.dec_div = st_q.dec_div;
      end else if (st_q.dec_div == 4'h0) begin
         st_d.dec_div = DEC_CYC - 4'h1;
      end else begin
         st_d.dec_div = st_q.dec_div - 4'h1;
      end

      // Countdown to zero, then stop until reloaded
      if (dec_en && st_q.brg_run) begin // R23
         if (st_q.brg_cnt == 7'h00) begin
            st_d.brg_run = 1'b0;
         end else begin
            st_d.brg_cnt = st_q.brg_cnt - 7'h01;
         end
      end

      // Rewrite window runs down after each accepted buffer write
      if (st_q.wwin != 3'h0) begin
         st_d.wwin = st_q.wwin - 3'h1;
      end

      // Register reads, data stand in the next cycle
      if (i_bus.rd) begin
         case (i_bus.addr)
            `I2CMS_OFS_CTRL2: begin
               st_d.rdata[`I2CMS_CTRL2_SEN] = st_q.start_enable_bit;
               st_d.rdata[`I2CMS_CTRL2_RESTART_ENABLE_BIT] = st_q.restart_enable_bit;
               st_d.rdata[`I2CMS_CTRL2_ACK_DATA_BIT] = st_q.ack_dt;
               st_d.rdata[`I2CMS_CTRL2_ACK_STATUS_FLAG] = st_q.ack_stat;
            end
            `I2CMS_OFS_STATUS: begin
               st_d.rdata[`I2CMS_STATUS_BF] = st_q.bf;
               st_d.rdata[`I2CMS_STATUS_BEGIN] = st_q.bdet;
            end
            `I2CMS_OFS_RELOAD: begin
               st_d.rdata = {1'b0, st_q.reload};
            end
            `I2CMS_OFS_SBUF: begin
               st_d.rdata = st_q.sbuf;
            end
            `I2CMS_OFS_FLAGS: begin
               st_d.rdata[`I2CMS_FLAGS_IRQ] = st_q.irqf;
               st_d.rdata[`I2CMS_FLAGS_BCL] = st_q.bclf;
               st_d.rdata[`I2CMS_FLAGS_WRITE_COLLISION_FLAG] = st_q.write_collision_flag;
            end
            `I2CMS_OFS_CONFIG: begin
               st_d.rdata[`I2CMS_CONFIG_EN] = st_q.en;
            end
            // Unmapped addresses read as zero
            default: begin
               st_d.rdata = `I2CMS_BYTE_RST;
            end
         endcase
      end

      // Register writes; flag clears come before hardware sets
      if (i_bus.wr) begin
         case (i_bus.addr)
            `I2CMS_OFS_CTRL2: begin
               st_d.ack_dt = i_bus.wdata[`I2CMS_CTRL2_ACK_DATA_BIT];
               // Low control bits only act when nothing is running
               if (st_q.phase == i2cms_pkg::PH_IDLE && st_q.en) begin // R8 R12 R14
                  if (i_bus.wdata[`I2CMS_CTRL2_SEN]) begin
                     st_d.start_enable_bit = 1'b1;
                     st_d.phase = i2cms_pkg::PH_ST_ARM;
                  end else if (i_bus.wdata[`I2CMS_CTRL2_RESTART_ENABLE_BIT]) begin
                     // Pull SCL low and wait to see it low
                     st_d.restart_enable_bit = 1'b1;
                     st_d.scl_oe_n = 1'b0; // R9
                     st_d.phase = i2cms_pkg::PH_RS_LOW;
                  end
               end
            end
            `I2CMS_OFS_RELOAD: begin
               st_d.reload = i_bus.wdata[6:0];
            end
            `I2CMS_OFS_SBUF: begin
               sw_w = 1'b1;
            end
            `I2CMS_OFS_FLAGS: begin
               // Write one to clear
               if (i_bus.wdata[`I2CMS_FLAGS_IRQ]) begin
                  st_d.irqf = 1'b0;
               end
               if (i_bus.wdata[`I2CMS_FLAGS_BCL]) begin
                  st_d.bclf = 1'b0;
               end
               if (i_bus.wdata[`I2CMS_FLAGS_WRITE_COLLISION_FLAG]) begin
                  st_d.write_collision_flag = 1'b0; // R22
               end
            end
            `I2CMS_OFS_CONFIG: begin
               st_d.en = i_bus.wdata[`I2CMS_CONFIG_EN];
            end
            // Unmapped writes are dropped
            default: begin
               st_d.en = st_d.en;
            end
         endcase
      end

      // Shift buffer write handling by phase
      if (sw_w) begin
         case (st_q.phase)
            i2cms_pkg::PH_IDLE: begin
               // Accepted: load byte, mark full, start shifting
               if (st_q.en) begin
                  st_d.sbuf = i_bus.wdata;
                  st_d.shreg = i_bus.wdata;
                  st_d.bf = 1'b1; // R15
                  st_d.bitcnt = 4'h0;
                  st_d.wwin = WIN_CYC;
                  st_d.scl_oe_n = 1'b0;
                  st_d.phase = i2cms_pkg::PH_TX_FALL; // R15
               end
            end
            i2cms_pkg::PH_TX_FALL, i2cms_pkg::PH_TX_LOW,
            i2cms_pkg::PH_TX_WAIT, i2cms_pkg::PH_TX_HIGH: begin
               // Always flagged; a fast rewrite still lands and may corrupt
               st_d.write_collision_flag = 1'b1; // R21
               if (st_q.wwin != 3'h0) begin
                  st_d.sbuf = i_bus.wdata; // R21
                  st_d.shreg = i_bus.wdata;
               end
            end
            // Start or restart running: buffer untouched
            default: begin
               st_d.write_collision_flag = 1'b1; // R7 R14
            end
         endcase
      end

      // Sequencer
      case (st_q.phase)
         i2cms_pkg::PH_IDLE: begin
            st_d.phase = st_d.phase;
         end
         i2cms_pkg::PH_ST_ARM: begin
            // Both low at the start is a collision
            if (!lvl.scl && !lvl.sda) begin
               bcl = 1'b1; // R6
            end else if (lvl.scl && lvl.sda) begin
               load = 1'b1; // R4
               st_d.phase = i2cms_pkg::PH_ST_WAIT;
            end
         end
         i2cms_pkg::PH_ST_WAIT: begin
            // SCL low before SDA is driven is a collision
            if (!lvl.scl) begin
               bcl = 1'b1; // R6
            end else if (tmo) begin
               if (lvl.sda) begin
                  st_d.sda_oe_n = 1'b0; // R4
                  st_d.bdet = 1'b1; // R4
                  load = 1'b1; // R5
                  st_d.phase = i2cms_pkg::PH_ST_HOLD;
               end else begin
                  bcl = 1'b1;
               end
            end
         end
         i2cms_pkg::PH_ST_HOLD: begin
            // Hold SDA low one more period, then finish
            if (tmo) begin
               st_d.start_enable_bit = 1'b0; // R5
               st_d.irqf = 1'b1;
               st_d.phase = i2cms_pkg::PH_IDLE;
            end
         end
         i2cms_pkg::PH_RS_LOW: begin
            // Once SCL is seen low, release SDA for a period
            if (!lvl.scl) begin
               load = 1'b1; // R9
               st_d.sda_oe_n = 1'b1; // R9
               st_d.phase = i2cms_pkg::PH_RS_SDA;
            end
         end
         i2cms_pkg::PH_RS_SDA: begin
            if (tmo) begin
               if (lvl.sda) begin
                  st_d.scl_oe_n = 1'b1; // R9
                  st_d.phase = i2cms_pkg::PH_RS_RISE;
               end else begin
                  bcl = 1'b1; // R13
               end
            end
         end
         i2cms_pkg::PH_RS_RISE: begin
            // Clock arbitration: no count until SCL is high
            if (lvl.scl) begin
               if (!lvl.sda) begin
                  bcl = 1'b1; // R13
               end else begin
                  load = 1'b1; // R3 R10
                  st_d.phase = i2cms_pkg::PH_RS_HIGH;
               end
            end
         end
         i2cms_pkg::PH_RS_HIGH: begin
            // Both high for one period, then drive the start edge
            if (!lvl.scl) begin
               bcl = 1'b1; // R13
            end else if (tmo) begin
               st_d.sda_oe_n = 1'b0; // R10
               load = 1'b1;
               st_d.phase = i2cms_pkg::PH_RS_SDALO;
            end
         end
         i2cms_pkg::PH_RS_SDALO: begin
            // Start seen on the lines sets begin at once
            if (lvl.scl && !lvl.sda) begin
               st_d.bdet = 1'b1; // R11
            end
            if (tmo) begin
               st_d.restart_enable_bit = 1'b0; // R10
               st_d.irqf = 1'b1; // R11
               st_d.phase = i2cms_pkg::PH_IDLE;
            end
         end
         i2cms_pkg::PH_TX_FALL: begin
            // SCL has just fallen: change SDA, then count the low half
            load = 1'b1; // R16
            st_d.phase = i2cms_pkg::PH_TX_LOW;
            if (st_q.bitcnt < 4'h8) begin
               st_d.sda_oe_n = st_q.shreg[3'(4'h7 - st_q.bitcnt)]; // R16 R17
            end else if (st_q.bitcnt == 4'h8) begin
               st_d.bf = 1'b0; // R18
               st_d.sda_oe_n = 1'b1; // R18
            end else begin
               // Ninth fall: sample acknowledge, halt holding SCL low
               st_d.ack_stat = lvl.sda; // R19
               st_d.irqf = 1'b1; // R20
               load = 1'b0; // R20
               st_d.phase = i2cms_pkg::PH_IDLE;
            end
         end
         i2cms_pkg::PH_TX_LOW: begin
            if (tmo) begin
               st_d.scl_oe_n = 1'b1; // R16
               st_d.phase = i2cms_pkg::PH_TX_WAIT;
            end
         end
         i2cms_pkg::PH_TX_WAIT: begin
            // Wait out any slave stretching the clock
            if (lvl.scl) begin
               load = 1'b1; // R3
               st_d.phase = i2cms_pkg::PH_TX_HIGH;
            end
         end
         i2cms_pkg::PH_TX_HIGH: begin
            if (tmo) begin
               st_d.scl_oe_n = 1'b0; // R2 R16
               st_d.bitcnt = st_q.bitcnt + 4'h1;
               st_d.phase = i2cms_pkg::PH_TX_FALL;
            end
         end
         default: begin
            bcl = 1'b1;
         end
      endcase

      // Divider reload from the seven-bit field
      if (load) begin
         st_d.brg_cnt = st_q.reload; // R3
         st_d.brg_run = 1'b1;
      end

      // Collision aborts the condition and releases the bus
      if (bcl) begin
         st_d.bclf = 1'b1; // R6 R13
         st_d.start_enable_bit = 1'b0;
         st_d.restart_enable_bit = 1'b0;
         st_d.brg_run = 1'b0;
         st_d.scl_oe_n = 1'b1;
         st_d.sda_oe_n = 1'b1;
         st_d.phase = i2cms_pkg::PH_IDLE;
      end

      // Disabled module sits idle with both lines released
      if (!st_q.en) begin
         st_d.phase = i2cms_pkg::PH_IDLE; // R25
         st_d.start_enable_bit = 1'b0;
         st_d.restart_enable_bit = 1'b0;
         st_d.bf = 1'b0;
         st_d.bdet = 1'b0;
         st_d.brg_run = 1'b0;
         st_d.scl_oe_n = 1'b1;
         st_d.sda_oe_n = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= '0; // R25
         st_q.phase <= i2cms_pkg::PH_IDLE;
         st_q.reload <= `I2CMS_RELOAD_RST;
         st_q.scl_oe_n <= 1'b1;
         st_q.sda_oe_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from the state register
   // ----------------------------------------------------------------
   assign o_rdata = st_q.rdata;
   // Open-drain data is a constant low taken from a reset-cleared field
   assign o_line.scl = st_q.rdata[7] & 1'b0;
   assign o_line.sda = st_q.rdata[7] & 1'b0;
   assign o_line_oe_n.scl = st_q.scl_oe_n;
   assign o_line_oe_n.sda = st_q.sda_oe_n;
endmodule

// ---- rtl/i2cms_sync.sv ----
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change is accepted once stages two and
// three agree, so a single metastable sample never reaches the sequencer.
module i2cms_sync #(
   parameter int W = 2
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_lvl
);
   // ----------------------------------------------------------------
   // Width check
   // ----------------------------------------------------------------
   if (W < 1) begin : g_chk
      $error("i2cms_sync width must be at least one");
   end

   // ----------------------------------------------------------------
   // One synchroniser per line
   // ----------------------------------------------------------------
   for (genvar g = 0; g < W; g++) begin : g_bit
      logic s1_q; // Only read by s2_q
      logic s2_q;
      logic s3_q;
      logic lvl_q; // Accepted level, idle bus is high
      // Shift the pin through three stages
      always_ff @(posedge i_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            lvl_q <= 1'b1;
         end else begin
            s1_q <= i_pin[g];
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Accept only an agreed level
            if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
         end
      end
      assign o_lvl[g] = lvl_q;
   end
endmodule

// ---- tb/i2cms_seq_sva.sv ----
`timescale 1ns/1ps
module i2cms_seq_chk (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire i2cms_pkg::i2cms_bus_req_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic i_sleep,
   input wire i2cms_pkg::i2cms_line_t i_line,
   input wire i2cms_pkg::i2cms_line_t o_line,
   input wire i2cms_pkg::i2cms_line_t o_line_oe_n
);
   // ----
   // Pin settle counter
   // ----
   logic [2:0] quiet_q; // Cycles with pins unchanged, saturating
   logic [1:0] pins_q; // Pin levels one cycle back
   // Synchroniser needs several still cycles before the core sees a level
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         quiet_q <= 3'h0;
         pins_q <= 2'h3;
      end else begin
         pins_q <= i_line;
         if (i_line != pins_q) begin
            quiet_q <= 3'h0;
         end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_sleep_hold;
      i_sleep && $past(i_sleep) && $past(i_sleep, 2) && !$past(i_bus.wr) && quiet_q > 3'h4
      |-> $stable(o_line_oe_n.scl);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("clock moved in sleep");
   property p_sda_rel;
      $rose(o_line_oe_n.sda) |-> !$past(o_line_oe_n.scl) || !$past(i_line.scl) || $past(i_bus.wr);
   endproperty
   a_sda_rel: assert property (p_sda_rel) else $error("data released with clock high");
   property p_hi_min;
      $rose(o_line_oe_n.scl) |-> ##1 (o_line_oe_n.scl || $past(i_bus.wr)) [*3];
   endproperty
   a_hi_min: assert property (p_hi_min) else $error("clock high phase too short");
   property p_lo_min;
      $fell(o_line_oe_n.scl) |-> (!o_line_oe_n.scl || $past(i_bus.wr)) [*3];
   endproperty
   a_lo_min: assert property (p_lo_min) else $error("clock low phase too short");
   property p_start_hold;
      $fell(o_line_oe_n.sda) && o_line_oe_n.scl |-> (!o_line_oe_n.sda || $past(i_bus.wr)) [*3];
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start edge not held");
   property p_start_pre;
      $fell(o_line_oe_n.sda) && o_line_oe_n.scl |-> $past(o_line_oe_n.scl, 3);
   endproperty
   a_start_pre: assert property (p_start_pre) else $error("start without high period");
   property p_rd_zero;
      !$past(i_bus.rd) |-> o_rdata == 8'h00;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle");
   property p_no_drive;
      o_line == 2'b00;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("pin data not low");
   c_start: cover property ($fell(o_line_oe_n.sda) && o_line_oe_n.scl);
   c_sleep: cover property (i_sleep && !o_line_oe_n.scl);
   c_read: cover property (i_bus.rd);
endmodule
bind i2cms_seq i2cms_seq_chk u_chk (.i_clk, .i_resetn, .i_bus, .o_rdata, .i_sleep, .i_line,
   .o_line, .o_line_oe_n);

// ---- tb/i2cms_seq_tb.sv ----
`timescale 1ns/1ps
`include "i2cms_params.svh"
module i2cms_seq_tb;
   // ----
   // Stimulus and observation
   // ----
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_sleep = 1'b0;
   logic slp_en = 1'b0; // Random sleep allowed
   logic ack = 1'b1; // Slave acknowledges
   logic [3:0] stretch = 4'h0;
   i2cms_pkg::i2cms_line_t jam_n = 2'b11;
   i2cms_pkg::i2cms_bus_req_t i_bus = '0;
   i2cms_pkg::i2cms_line_t i_line, o_line, oe_n;
   logic [7:0] o_rdata, seen, rb, sb;
   logic [31:0] rng = 32'h3EE7E965;
   int fail_count = 0;
   int checks_done = 0;
   always #25 i_clk = ~i_clk;
   i2cms_seq uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus(i_bus), .o_rdata(o_rdata),
      .i_sleep(i_sleep), .i_line(i_line), .o_line(o_line), .o_line_oe_n(oe_n));
   i2cms_slave peer (.i_clk(i_clk), .i_resetn(i_resetn), .i_oe_n(oe_n), .i_ack(ack),
      .i_stretch(stretch), .i_jam_n(jam_n), .o_wire(i_line), .o_byte(seen));
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // Occasional sleep cycles stretch any divider count they land in
   always @(posedge i_clk) i_sleep <= slp_en & ((rnd() & 32'h7) == 32'h0);
   // ----
   // Bus cycles and comparisons
   // ----
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      i_bus <= '0;
   endtask
   task automatic chk(input string n, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, m, e);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_bus <= '0;
      #1 chk(n, e, o_rdata & m);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Poll the event flag with a bound, then clear it as software must
   task automatic wait_irq();
      int i;
      for (i = 0; i < 400; i++) begin
         rchk("no collision", `I2CMS_OFS_FLAGS, 8'h02, 8'h00);
         if (o_rdata[`I2CMS_FLAGS_IRQ] === 1'b1) break;
      end
      if (i == 400) begin
         chk("irq wait", 8'h01, 8'h00);
         summarize();
      end
      wr(`I2CMS_OFS_FLAGS, 8'h01);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      rchk("reload reset", `I2CMS_OFS_RELOAD, 8'h7F, 8'h63);
      wr(`I2CMS_OFS_CONFIG, 8'h01);
      wr(`I2CMS_OFS_RELOAD, 8'h03);
      wr(`I2CMS_OFS_CTRL2, 8'h01);
      wr(`I2CMS_OFS_SBUF, 8'hA5);
      wr(`I2CMS_OFS_CTRL2, 8'h02);
      rchk("write_collision_flag start", `I2CMS_OFS_FLAGS, 8'h04, 8'h04);
      rchk("sbuf kept", `I2CMS_OFS_SBUF, 8'hFF, 8'h00);
      wait_irq();
      rchk("begin seen", `I2CMS_OFS_STATUS, 8'h08, 8'h08);
      rchk("start enables", `I2CMS_OFS_CTRL2, 8'h03, 8'h00);
      chk("lines after start", 8'h02, {6'h0, oe_n});
      wr(`I2CMS_OFS_FLAGS, 8'h04);
      slp_en <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         sb = 8'(rnd());
         ack <= rng[8];
         stretch <= rng[12:9];
         wr(`I2CMS_OFS_SBUF, sb);
         if (k == 1 || k == 2) begin
            // Early rewrite lands, a late one is dropped
            if (k == 2) repeat (6) @(posedge i_clk);
            wr(`I2CMS_OFS_SBUF, ~sb);
            if (k == 1) sb = ~sb;
            rchk("sbuf rewrite", `I2CMS_OFS_SBUF, 8'hFF, sb);
            rchk("write_collision_flag shift", `I2CMS_OFS_FLAGS, 8'h04, 8'h04);
            wr(`I2CMS_OFS_FLAGS, 8'h04);
         end else begin
            rchk("full set", `I2CMS_OFS_STATUS, 8'h01, 8'h01);
         end
         if (k == 3) wr(`I2CMS_OFS_CTRL2, 8'h02);
         wait_irq();
         if (k != 1) chk("byte on wire", sb, seen);
         rchk("ack status", `I2CMS_OFS_CTRL2, 8'h43, {1'b0, ~ack, 6'h0});
         rchk("full clear", `I2CMS_OFS_STATUS, 8'h01, 8'h00);
         chk("lines after byte", 8'h01, {6'h0, oe_n});
      end
      wr(`I2CMS_OFS_CTRL2, 8'h02);
      wr(`I2CMS_OFS_SBUF, 8'h3C);
      wr(`I2CMS_OFS_CTRL2, 8'h01);
      rchk("write_collision_flag restart", `I2CMS_OFS_FLAGS, 8'h04, 8'h04);
      wait_irq();
      rchk("sbuf locked", `I2CMS_OFS_SBUF, 8'hFF, sb);
      rchk("restart enables", `I2CMS_OFS_CTRL2, 8'h03, 8'h00);
      chk("lines after restart", 8'h02, {6'h0, oe_n});
      slp_en <= 1'b0;
      jam_n <= 2'b00;
      repeat (6) @(posedge i_clk);
      wr(`I2CMS_OFS_CTRL2, 8'h01);
      rchk("collision", `I2CMS_OFS_FLAGS, 8'h02, 8'h02);
      rchk("start aborted", `I2CMS_OFS_CTRL2, 8'h01, 8'h00);
      chk("lines released", 8'h03, {6'h0, oe_n});
      summarize();
   end
endmodule

// ---- tb/i2cms_slave.sv ----
`timescale 1ns/1ps
// Addressed slave on an open-drain pair with pull-ups
module i2cms_slave (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire i2cms_pkg::i2cms_line_t i_oe_n, // Master enables, low pulls
   input wire logic i_ack, // Answer the ninth clock low
   input wire logic [3:0] i_stretch, // Low cycles held after each fall
   input wire i2cms_pkg::i2cms_line_t i_jam_n, // Another master pulling
   output i2cms_pkg::i2cms_line_t o_wire, // Resolved pin levels
   output logic [7:0] o_byte // First eight bits of the last byte
);
   logic [3:0] cnt_q; // Rising clocks since start or ninth fall
   logic [3:0] hold_q; // Stretch countdown
   logic ack_q; // Acknowledge drive
   i2cms_pkg::i2cms_line_t prev_q; // Wire one cycle back
   // Released lines float to the pull-up level
   assign o_wire.scl = i_oe_n.scl & i_jam_n.scl & (hold_q == 4'h0);
   assign o_wire.sda = i_oe_n.sda & i_jam_n.sda & !ack_q;
   // Bit capture, acknowledge and stretching
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= 4'h0;
         hold_q <= 4'h0;
         ack_q <= 1'b0;
         prev_q <= 2'h3;
         o_byte <= 8'h00;
      end else begin
         prev_q <= o_wire;
         if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
         end
         if (prev_q.scl && !o_wire.scl) begin
            // Stretch holds the clock low past the master's release
            hold_q <= i_stretch;
            ack_q <= (cnt_q == 4'h8) && i_ack;
            if (cnt_q == 4'h9) begin
               cnt_q <= 4'h0;
            end
         end else if (!prev_q.scl && o_wire.scl) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q < 4'h8) begin
               o_byte <= {o_byte[6:0], o_wire.sda};
            end
         end else if (o_wire.scl && prev_q.sda && !o_wire.sda) begin
            cnt_q <= 4'h0;
         end
      end
   end
endmodule
